/* File: hdl/scd_pkg.sv */
// Package for the serial command decoder: codes, field positions, types
package scd_pkg;

    // ------------------------------------------------------------
    // Command byte field positions
    // ------------------------------------------------------------
    localparam int CMD_KIND_BIT   = 7;   // Register access or conversion
    localparam int ARRAY_BIT      = 6;   // Array access flag
    localparam int REPEAT_BIT     = 6;   // Repeat conversion flag
    localparam int CHAN_HI        = 5;   // Channel select field
    localparam int CHAN_LO        = 4;
    localparam int DIR_BIT        = 3;   // Transfer direction
    localparam int PTR_HI         = 5;   // Setup entry pointer
    localparam int PTR_LO         = 3;
    localparam int CODE_HI        = 2;   // Register type / operation code
    localparam int CODE_LO        = 0;

    // ------------------------------------------------------------
    // Register type codes
    // ------------------------------------------------------------
    localparam logic [2:0] REG_OFFSET = 3'h1;
    localparam logic [2:0] REG_GAIN   = 3'h2;
    localparam logic [2:0] REG_CONFIG = 3'h3;
    localparam logic [2:0] REG_SETUP  = 3'h5;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    localparam logic [2:0] OP_CONVERT  = 3'h0;
    localparam logic [2:0] OP_SELF_OFS = 3'h1;
    localparam logic [2:0] OP_SELF_GN  = 3'h2;
    localparam logic [2:0] OP_SYS_OFS  = 3'h5;
    localparam logic [2:0] OP_SYS_GN   = 3'h6;

    // ------------------------------------------------------------
    // Sizes, counts and reset values
    // ------------------------------------------------------------
    localparam int         NUM_CHAN      = 4;       // Physical channels
    localparam logic [6:0] RESYNC_ONES   = 7'h7F;   // 15 fill bytes + 7 ones of end byte
    localparam logic [7:0] CMD_RESET     = 8'h00;
    localparam logic [2:0] BIT_RESET     = 3'h0;
    localparam logic [1:0] CHAN_RESET    = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCD_CMD_MODE = 3'b001,   // Waiting for a command byte
        SCD_XFER     = 3'b010,   // Register data transfer under way
        SCD_CONVERT  = 3'b100    // Conversion or calibration under way
    } scd_state_t;

    typedef struct packed {
        logic       reg_access;          // Byte was a register-access command
        logic       array_access_flag;   // Whole array of the type
        logic [1:0] channel_select_field;
        logic       read_dir;            // 1: device returns data
        logic [2:0] register_type_select;
        logic       repeat_conversion_flag;
        logic [2:0] setup_entry_pointer;
        logic [2:0] operation_code;
    } scd_cmd_t;

endpackage : scd_pkg

/* File: hdl/scd_decoder.sv */
// Serial command byte decoder with resynchronisation and conversion-ready flag
`timescale 1ns/100ps
//
// Contract
// - MSB zero: decode as register access
// - MSB one: decode as conversion command
// - Bit 6 set: transfer whole register array
// - Array words MSB first, channel 0 upward
// - Bit 3: zero write, one read
// - Bit 6: single settled or continuous conversions
// - Three-bit pointer picks channel-setup entry
// - Idle in command mode; first byte is command
// - Continuous mode flags completed conversions on data out
module scd_decoder
    import scd_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Serial port pins, asynchronous to clk
    input  wire logic       sclk_pin,
    input  wire logic       sdi_pin,
    // Serial data out, idle high, low marks a ready result
    output logic            sdo_pin,
    // Decoded command
    output scd_cmd_t        cmd,
    output logic            cmd_valid,
    output logic            cmd_reserved,
    // Register transfer sequencing
    output logic [1:0]      xfer_channel,
    output logic            xfer_active,
    input  wire logic       word_done,
    // Conversion engine
    output logic            conv_active,
    input  wire logic       conv_done,
    // Port state
    output logic            command_mode,
    output logic            resync_seen
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_sync;    // Two stages, only stage 1 is read
    logic [1:0] sdi_sync;
    logic       sclk_prev;    // Previous synchronised clock level

    // Two flops each; stage 0 feeds stage 1 only
    always_ff @(posedge clk) begin
        sclk_sync <= {sclk_sync[0], sclk_pin};
        sdi_sync  <= {sdi_sync[0], sdi_pin};
        sclk_prev <= sclk_sync[1];
    end

    // Rising edge of the serial clock samples the data input
    wire bit_strobe = sclk_sync[1] & ~sclk_prev;
    wire bit_in     = sdi_sync[1];

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    scd_state_t state;          // Port state
    scd_state_t next_state;
    logic [7:0] shift;          // Command shift register
    logic [2:0] bit_count;      // Bits of the current byte
    logic [6:0] ones_run;       // Consecutive ones, saturating
    logic [1:0] chan_index;     // Array channel sequencer
    logic       result_ready;   // Continuous result waiting

    // ------------------------------------------------------------
    // Resync detection
    // ------------------------------------------------------------
    // Counting ones rather than aligned bytes lets the sequence
    // recover a port that has slipped off its byte boundary.
    wire run_full  = (ones_run == RESYNC_ONES);
    wire resync    = bit_strobe & ~bit_in & run_full;
    wire next_full = (ones_run == RESYNC_ONES);

    // ------------------------------------------------------------
    // Byte assembly and decode
    // ------------------------------------------------------------
    wire [7:0] next_shift = {shift[6:0], bit_in};
    wire       byte_end   = bit_strobe & (bit_count == 3'h7);
    wire       cmd_take   = byte_end & (state == SCD_CMD_MODE) & ~resync;

    wire       kind_conv  = next_shift[CMD_KIND_BIT];
    wire [2:0] low_code   = next_shift[CODE_HI:CODE_LO];

    // Register type validity
    wire reg_ok  = (low_code == REG_OFFSET) | (low_code == REG_GAIN)
                 | (low_code == REG_CONFIG) | (low_code == REG_SETUP);
    // Operation validity
    wire op_ok   = (low_code == OP_CONVERT)  | (low_code == OP_SELF_OFS)
                 | (low_code == OP_SELF_GN)  | (low_code == OP_SYS_OFS)
                 | (low_code == OP_SYS_GN);
    wire code_ok = kind_conv ? op_ok : reg_ok;

    // Field split, each meaning applies only to its command kind
    scd_cmd_t next_cmd;
    always_comb begin
        next_cmd                        = '0;
        next_cmd.reg_access             = ~kind_conv;
        if (!kind_conv) begin
            next_cmd.array_access_flag    = next_shift[ARRAY_BIT];
            next_cmd.channel_select_field = next_shift[CHAN_HI:CHAN_LO];
            next_cmd.read_dir             = next_shift[DIR_BIT];
            next_cmd.register_type_select = low_code;
        end else begin
            next_cmd.repeat_conversion_flag = next_shift[REPEAT_BIT];
            next_cmd.setup_entry_pointer    = next_shift[PTR_HI:PTR_LO];
            next_cmd.operation_code         = low_code;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    wire last_word = ~cmd.array_access_flag
                   | (chan_index == 2'(NUM_CHAN - 1));
    wire conv_end  = conv_done & ~cmd.repeat_conversion_flag;

    always_comb begin
        next_state = state;
        case (state)
            SCD_CMD_MODE: begin
                // Reserved codes leave the port waiting
                if (cmd_take && code_ok) begin
                    next_state = kind_conv ? SCD_CONVERT : SCD_XFER;
                end
            end
            SCD_XFER: begin
                if (word_done && last_word) begin
                    next_state = SCD_CMD_MODE;
                end
            end
            SCD_CONVERT: begin
                // Continuous runs end only by resync
                if (conv_end) begin
                    next_state = SCD_CMD_MODE;
                end
            end
            default: begin
                next_state = SCD_CMD_MODE;
            end
        endcase
        if (resync) begin
            next_state = SCD_CMD_MODE;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Bit counter and shift register
    always_ff @(posedge clk) begin
        if (!resetn || resync) begin
            bit_count <= BIT_RESET;
            shift     <= CMD_RESET;
        end else if (bit_strobe) begin
            bit_count <= bit_count + 3'h1;
            shift     <= next_shift;
        end
    end

    // Ones run, saturates at the threshold
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ones_run <= '0;
        end else if (bit_strobe) begin
            ones_run <= !bit_in ? 7'h00 : (next_full ? ones_run : ones_run + 7'h01);
        end
    end

    // Port state and decoded command
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= SCD_CMD_MODE;
            cmd   <= '0;
        end else begin
            state <= next_state;
            if (cmd_take && code_ok) begin
                cmd <= next_cmd;
            end
        end
    end

    // Strobes, one cycle each
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_valid    <= 1'b0;
            cmd_reserved <= 1'b0;
            resync_seen  <= 1'b0;
        end else begin
            cmd_valid    <= cmd_take & code_ok;
            cmd_reserved <= cmd_take & ~code_ok;
            resync_seen  <= resync;
        end
    end

    // Channel sequencer: array starts at channel 0, else the selected one
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_index <= CHAN_RESET;
        end else if (cmd_take && code_ok) begin
            chan_index <= next_shift[ARRAY_BIT] ? CHAN_RESET
                                                : next_shift[CHAN_HI:CHAN_LO];
        end else if (state == SCD_XFER && word_done && !last_word) begin
            chan_index <= chan_index + 2'h1;
        end
    end

    // Result flag: set wins over the clearing serial clock edge
    always_ff @(posedge clk) begin
        if (!resetn || resync) begin
            result_ready <= 1'b0;
        end else if (state == SCD_CONVERT && conv_done && cmd.repeat_conversion_flag) begin
            result_ready <= 1'b1;
        end else if (bit_strobe) begin
            result_ready <= 1'b0;
        end
    end

    // Data out from a flop: low while a continuous result waits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sdo_pin <= 1'b1;
        end else begin
            sdo_pin <= ~result_ready;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    assign xfer_channel = chan_index;
    assign xfer_active  = (state == SCD_XFER);
    assign conv_active  = (state == SCD_CONVERT);
    assign command_mode = (state == SCD_CMD_MODE);

endmodule : scd_decoder

/* File: verification/scd_host_model.sv */
// Host side model driving the serial command port
`timescale 1ns/100ps
module scd_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins toward the decoder
    output logic      sclk_pin,
    output logic      sdi_pin
);
    // Serial clock stands low outside bytes
    initial begin
        sclk_pin = 1'b0;
        sdi_pin  = 1'b0;
    end
    // One byte MSB first, phases of 4 and 5 clocks keep the 3 clock minimum
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk) sdi_pin = b[i];
            repeat (4) @(negedge clk);
            sclk_pin = 1'b1;
            repeat (4) @(negedge clk);
            sclk_pin = 1'b0;
        end
        sdi_pin = ~b[0];    // No pull on data in, so never leave the last bit showing
    endtask : send_byte
    // Fifteen fill bytes then the end byte
    task automatic resync();
        repeat (15) send_byte(8'hFF);
        send_byte(8'hFE);
    endtask : resync
endmodule : scd_host_model

/* File: verification/scd_decoder_chk.sv */
// Port checker for the serial command decoder
`timescale 1ns/100ps
module scd_decoder_chk
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Serial pins
    input wire logic       sclk_pin,
    input wire logic       sdi_pin,
    input wire logic       sdo_pin,
    // Decoder outputs and handshakes
    input wire scd_cmd_t   cmd,
    input wire logic       cmd_valid,
    input wire logic       cmd_reserved,
    input wire logic [1:0] xfer_channel,
    input wire logic       xfer_active,
    input wire logic       word_done,
    input wire logic       conv_active,
    input wire logic       conv_done,
    input wire logic       command_mode,
    input wire logic       resync_seen
);
    // ------------------------------------------------------------
    // Helpers and properties, all on clk
    // ------------------------------------------------------------
    logic reg_ok;    // Known type, conversion fields clear
    logic op_ok;     // Known operation, register fields clear
    assign reg_ok = cmd[6:0] == 7'h00 && (cmd.register_type_select inside
        {REG_OFFSET, REG_GAIN, REG_CONFIG, REG_SETUP});
    assign op_ok = cmd[13:7] == 7'h00 && (cmd.operation_code inside
        {OP_CONVERT, OP_SELF_OFS, OP_SELF_GN, OP_SYS_OFS, OP_SYS_GN});
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_reg_kind; cmd_valid && cmd.reg_access |-> xfer_active && reg_ok; endproperty
    a_reg_kind: assert property (p_reg_kind) else $error("bad register decode");
    property p_conv_kind; cmd_valid && !cmd.reg_access |-> conv_active && op_ok; endproperty
    a_conv_kind: assert property (p_conv_kind) else $error("bad conversion decode");
    property p_chan; cmd_valid && cmd.reg_access && !cmd.array_access_flag
        |-> xfer_channel == cmd.channel_select_field; endproperty
    a_chan: assert property (p_chan) else $error("single word on wrong channel");
    property p_arr_first; cmd_valid && cmd.reg_access && cmd.array_access_flag
        |-> xfer_channel == 2'h0; endproperty
    a_arr_first: assert property (p_arr_first) else $error("array not from channel 0");
    property p_arr_step; xfer_active && cmd.array_access_flag && word_done && xfer_channel != 2'h3
        |=> xfer_active && xfer_channel == $past(xfer_channel) + 2'h1; endproperty
    a_arr_step: assert property (p_arr_step) else $error("array order broken");
    property p_xfer_end; xfer_active && word_done
        && (!cmd.array_access_flag || xfer_channel == 2'h3) |=> command_mode; endproperty
    a_xfer_end: assert property (p_xfer_end) else $error("transfer length wrong");
    property p_single; conv_active && conv_done && !cmd.repeat_conversion_flag
        |=> command_mode; endproperty
    a_single: assert property (p_single) else $error("single conversion not ended");
    property p_repeat; conv_active && conv_done && cmd.repeat_conversion_flag
        |=> conv_active ##1 !sdo_pin; endproperty
    a_repeat: assert property (p_repeat) else $error("no result flag on data out");
    property p_reserved; cmd_reserved |-> command_mode && !cmd_valid && $stable(cmd); endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code acted on");
    property p_resync; resync_seen |-> ##[0:2] (command_mode && sdo_pin); endproperty
    a_resync: assert property (p_resync) else $error("resync left mode");
    // Main scenarios reached
    cover property (cmd_valid && cmd.array_access_flag && cmd.reg_access);
    cover property (conv_done && cmd.repeat_conversion_flag);
    cover property (cmd_reserved);
endmodule : scd_decoder_chk
bind scd_decoder scd_decoder_chk u_chk (
    .clk(clk), .resetn(resetn), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .sdo_pin(sdo_pin),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_reserved(cmd_reserved),
    .xfer_channel(xfer_channel), .xfer_active(xfer_active), .word_done(word_done),
    .conv_active(conv_active), .conv_done(conv_done), .command_mode(command_mode),
    .resync_seen(resync_seen)
);

/* File: verification/scd_decoder_tb_top.sv */
// Testbench for the serial command decoder
`timescale 1ns/100ps
module scd_decoder_tb_top
    import scd_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic       clk = 1'b0;     // 40 MHz
    logic       resetn = 1'b0;  // Low for 12 cycles
    logic       word_done = 1'b0;
    logic       conv_done = 1'b0;
    logic       sclk_pin, sdi_pin, sdo_pin, cmd_valid, cmd_reserved, xfer_active;
    logic       conv_active, command_mode, resync_seen;
    scd_cmd_t   cmd;            // Decoded command
    logic [1:0] xfer_channel;   // Word being moved
    logic [7:0] b;              // Last accepted byte
    int         err_total = 0;
    int         comparisons = 0;
    int         n_valid = 0, n_res = 0, n_sync = 0;   // Pulse tallies
    logic [2:0] types [4] = '{REG_OFFSET, REG_GAIN, REG_CONFIG, REG_SETUP};
    logic [2:0] ops [5] = '{OP_CONVERT, OP_SELF_OFS, OP_SELF_GN, OP_SYS_OFS, OP_SYS_GN};
    logic [7:0] rsv [7] = '{8'h38, 8'h0C, 8'h4E, 8'h07, 8'h83, 8'hC4, 8'hBF};
    always #12.5 clk = ~clk;
    scd_host_model host (.clk(clk), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin));
    scd_decoder dut (
        .clk(clk), .resetn(resetn), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .sdo_pin(sdo_pin),
        .cmd(cmd), .cmd_valid(cmd_valid), .cmd_reserved(cmd_reserved),
        .xfer_channel(xfer_channel), .xfer_active(xfer_active), .word_done(word_done),
        .conv_active(conv_active), .conv_done(conv_done), .command_mode(command_mode),
        .resync_seen(resync_seen)
    );
    // Pulses last one cycle, so tally them here
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) n_valid++;
        if (cmd_reserved === 1'b1) n_res++;
        if (resync_seen === 1'b1) n_sync++;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // Expected decode: fields of the other kind read zero
    function automatic logic [14:0] expc(input logic [7:0] v);
        return v[7] ? {8'h00, v[6:0]} : {1'b1, v[6:0], 7'h00};
    endfunction : expc
    // One byte, then wait out the decode latency
    task automatic send(input logic [7:0] v, input int want_v, input int want_r);
        n_valid = 0;
        n_res = 0;
        host.send_byte(v);
        repeat (6) @(negedge clk);
        check("valid pulses", 15'(n_valid), 15'(want_v));
        check("reserved pulses", 15'(n_res), 15'(want_r));
    endtask : send
    // One-cycle word or conversion done pulse
    task automatic pulse(input logic w);
        word_done = w;
        conv_done = !w;
        @(negedge clk);
        word_done = 1'b0;
        conv_done = 1'b0;
        @(negedge clk);
    endtask : pulse
    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        check("idle mode", 15'(command_mode), 15'h0001);
        check("idle sdo", 15'(sdo_pin), 15'h0001);
        host.resync();
        repeat (6) @(negedge clk);
        check("resync pulse", 15'(n_sync), 15'h0001);
        // Single read on channel i, then array write, every type
        foreach (types[i]) begin
            b = {2'b00, 2'(i), 1'b1, types[i]};
            send(b, 1, 0);
            check("single cmd", cmd, expc(b));
            check("single chan", 15'(xfer_channel), 15'(i));
            pulse(1'b1);
            check("single end", 15'(command_mode), 15'h0001);
            b = {5'b01000, types[i]};
            send(b, 1, 0);
            check("array cmd", cmd, expc(b));
            for (int c = 0; c < NUM_CHAN; c++) begin
                check("array chan", 15'(xfer_channel), 15'(c));
                check("array busy", 15'(xfer_active), 15'h0001);
                pulse(1'b1);
            end
            check("array end", 15'(command_mode), 15'h0001);
        end
        // Reserved codes refused, last command stands
        foreach (rsv[i]) begin
            send(rsv[i], 0, 1);
            check("rsv cmd", cmd, expc(b));
            check("rsv mode", 15'(command_mode), 15'h0001);
        end
        // Every operation, pointer from 7 downward
        foreach (ops[i]) begin
            b = {2'b10, 3'(7 - i), ops[i]};
            send(b, 1, 0);
            check("conv cmd", cmd, expc(b));
            check("conv busy", 15'(conv_active), 15'h0001);
            pulse(1'b0);
            check("conv end", 15'(command_mode), 15'h0001);
        end
        // Continuous at pointer 0 flags its result until the first serial clock edge of the resync
        b = 8'hC0;
        send(b, 1, 0);
        check("cont cmd", cmd, expc(b));
        pulse(1'b0);
        @(negedge clk);
        check("cont sdo", 15'(sdo_pin), 15'h0000);
        check("cont busy", 15'(conv_active), 15'h0001);
        host.resync();
        repeat (6) @(negedge clk);
        check("resync mode", 15'(command_mode), 15'h0001);
        check("resync sdo", 15'(sdo_pin), 15'h0001);
        check("resync count", 15'(n_sync), 15'h0002);
        // Reset in mid-run, with a continuous result still flagged
        send(b, 1, 0);
        pulse(1'b0);
        @(negedge clk);
        check("cont sdo again", 15'(sdo_pin), 15'h0000);
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        check("reset mode", 15'(command_mode), 15'h0001);
        check("reset sdo", 15'(sdo_pin), 15'h0001);
        check("reset cmd", cmd, 15'h0000);
        end_sim();
    end
    // Run needs about 4100 cycles
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule : scd_decoder_tb_top
